// file: core/occ_top.sv
/*
 * Output compare channel with AHB-Lite register slave.
 * Assumes timers count on hclk and the fault pin is asynchronous.
 */
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
// Overview of operation
// (RULE_01) Enable bit 15 runs the channel
// (RULE_02) Stop-in-idle bit suspends channel during idle
// (RULE_03) Wide bit picks 32-bit or 16-bit compare
// (RULE_04) Fault flag set by hardware, software cannot write
// (RULE_05) Fault flag used and read only in 111
// (RULE_06) Timer select one picks third, zero second
// (RULE_07) Modes 111 and 110 produce PWM
// (RULE_08) Mode 101 starts low, continuous pulses
// (RULE_09) Mode 100 starts low, one pulse
// (RULE_10) Mode 011 toggles pin each compare event
// (RULE_11) Mode 010 starts high, event forces low
// (RULE_12) Mode 001 starts low, event forces high
// (RULE_13) Mode 000 leaves pin untouched; the code drives it low on entry to mode 000
// (RULE_14) Software avoids access right after disabling
// (RULE_15) Unimplemented control bits read zero
// (RULE_16) Compare event is timer equal to value
`timescale 1ns/100ps
`default_nettype none
module occ_top
    import occ_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Timebases and chip state
    input wire occ_pkg::occ_timers_t timers,
    input wire logic chip_idle,
    // Pins
    input wire logic fault_pin_n,
    output logic compare_output_pin,
    // Interrupt
    output logic irq
);
    import occ_pkg::*;

    logic [31:0] control;
    logic [31:0] primary_compare_value;
    logic [31:0] secondary_compare_value;
    logic [OCC_IRQ_WIDTH-1:0] irq_status;
    logic [OCC_IRQ_WIDTH-1:0] irq_mask;
    logic pwm_fault_flag;
    logic [2:0] prev_mode;
    logic prev_on;
    occ_state_t state;
    occ_state_t next_state;
    logic next_pin;
    logic fault_meta;
    logic fault_sync;

    // Address phase capture
    logic dp_write;
    logic dp_read;
    logic [7:0] dp_addr;

    wire addr_valid = hsel && hready && htrans == OCC_HTRANS_NONSEQ;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= addr_valid && hwrite;
            dp_read <= addr_valid && !hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Control fields
    wire enable = control[OCC_BIT_ENABLE];
    wire stop_in_idle = control[OCC_BIT_STOP_IDLE];
    wire wide_compare_select = control[OCC_BIT_WIDE];
    wire timer_source_select = control[OCC_BIT_TSEL];
    wire [2:0] compare_mode_select = control[OCC_MODE_LSB +: 3];

    // Channel runs only when on and not halted in idle
    wire running = enable && !(stop_in_idle && chip_idle); // see RULE_01 see RULE_02

    wire [31:0] timebase = timer_source_select ? timers.third_timer
                                               : timers.second_timer; // see RULE_06

    function automatic logic hits(input logic [31:0] t, input logic [31:0] v,
                                  input logic wide);
        hits = wide ? (t == v) : (t[15:0] == v[15:0]);
    endfunction

    wire match_primary = running
        && hits(timebase, primary_compare_value, wide_compare_select); // see RULE_03 see RULE_16
    wire match_secondary = running
        && hits(timebase, secondary_compare_value, wide_compare_select); // see RULE_16

    wire is_pwm = compare_mode_select[2:1] == 2'b11; // see RULE_07
    wire fault_mode = compare_mode_select == OCC_MODE_PWM_FAULT;
    wire fault_event = running && fault_mode && fault_sync; // see RULE_07
    // Entry into a mode or a fresh enable reinitialises the pin
    wire mode_entry = running && (!prev_on || prev_mode != compare_mode_select);

    // Fault pin synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_meta <= 1'b0;
            fault_sync <= 1'b0;
        end else begin
            fault_meta <= !fault_pin_n;
            fault_sync <= fault_meta;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_mode <= OCC_MODE_OFF;
            prev_on <= 1'b0;
        end else begin
            // Held while halted, so leaving idle resumes rather than re-enters
            if (running) begin
                prev_mode <= compare_mode_select;
            end
            prev_on <= enable && (running || prev_on);
        end
    end

    // Pin and sequencer next values
    always_comb begin
        next_pin = compare_output_pin;
        next_state = state;
        if (!enable) begin
            next_pin = 1'b0;
            next_state = OCC_ST_IDLE;
        end else if (!running) begin
            next_state = state; // Frozen while halted in idle
        end else if (mode_entry) begin
            next_pin = compare_mode_select == OCC_MODE_FALL; // see RULE_11 see RULE_12
            next_state = OCC_ST_WAIT_RISE; // see RULE_08 see RULE_09
        end else begin
            case (compare_mode_select)
                OCC_MODE_OFF: next_pin = compare_output_pin; // see RULE_13
                OCC_MODE_RISE: if (match_primary) next_pin = 1'b1; // see RULE_12
                OCC_MODE_FALL: if (match_primary) next_pin = 1'b0; // see RULE_11
                OCC_MODE_TOGGLE: if (match_primary) next_pin = !compare_output_pin; // see RULE_10
                OCC_MODE_SINGLE, OCC_MODE_TRAIN: begin
                    case (state)
                        OCC_ST_WAIT_RISE: if (match_primary) begin
                            next_pin = 1'b1;
                            next_state = OCC_ST_WAIT_FALL;
                        end
                        OCC_ST_WAIT_FALL: if (match_secondary) begin
                            next_pin = 1'b0;
                            // One pulse only, or repeat forever
                            next_state = compare_mode_select == OCC_MODE_TRAIN ?
                                OCC_ST_WAIT_RISE : OCC_ST_DONE; // see RULE_08 see RULE_09
                        end
                        OCC_ST_DONE: next_pin = 1'b0;
                        default: next_state = OCC_ST_WAIT_RISE;
                    endcase
                end
                default: begin
                    // PWM: primary sets duty end, secondary starts period
                    if (!is_pwm) begin
                        next_pin = 1'b0;
                    end else if (fault_event || pwm_fault_flag) begin
                        next_pin = 1'b0;
                    end else if (match_secondary) begin
                        next_pin = 1'b1;
                    end else if (match_primary) begin
                        next_pin = 1'b0;
                    end // see RULE_07
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_output_pin <= 1'b0;
            state <= OCC_ST_IDLE;
        end else begin
            compare_output_pin <= next_pin;
            state <= next_state;
        end
    end

    // Fault flag: set by fault, cleared by hardware when the mode is left,
    // or on re-entry or a fresh enable once the fault is gone; set wins over clear
    wire fault_clear = !fault_mode || (mode_entry && !fault_sync);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_fault_flag <= 1'b0;
        end else if (fault_event) begin
            pwm_fault_flag <= 1'b1; // see RULE_04
        end else if (fault_clear) begin
            pwm_fault_flag <= 1'b0;
        end
    end

    // Register writes
    wire wr_control = dp_write && dp_addr == OCC_ADDR_CONTROL;
    wire wr_primary = dp_write && dp_addr == OCC_ADDR_PRIMARY;
    wire wr_secondary = dp_write && dp_addr == OCC_ADDR_SECONDARY;
    wire wr_mask = dp_write && dp_addr == OCC_ADDR_IRQ_MASK;
    wire rd_status = dp_read && dp_addr == OCC_ADDR_IRQ_STATUS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control <= OCC_CONTROL_RESET;
            primary_compare_value <= OCC_VALUE_RESET;
            secondary_compare_value <= OCC_VALUE_RESET;
            irq_mask <= '0;
        end else begin
            // Fault bit is outside the write mask, so writes never touch it
            if (wr_control) control <= hwdata & OCC_CONTROL_WMASK; // see RULE_04 see RULE_15
            if (wr_primary) primary_compare_value <= hwdata;
            if (wr_secondary) secondary_compare_value <= hwdata;
            if (wr_mask) irq_mask <= hwdata[OCC_IRQ_WIDTH-1:0];
        end
    end

    // Sticky events; a new event in the clearing read's cycle survives
    wire [OCC_IRQ_WIDTH-1:0] irq_events = {fault_event && !pwm_fault_flag,
                                           match_primary && compare_mode_select != OCC_MODE_OFF};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (rd_status ? '0 : irq_status) | irq_events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read data, sampled from current state in the data phase
    wire [31:0] control_view = {control[31:5],
                                pwm_fault_flag && fault_mode, // see RULE_05
                                control[3:0]};
    logic [31:0] read_mux;
    always_comb begin
        case (dp_addr)
            OCC_ADDR_CONTROL: read_mux = control_view;
            OCC_ADDR_PRIMARY: read_mux = primary_compare_value;
            OCC_ADDR_SECONDARY: read_mux = secondary_compare_value;
            OCC_ADDR_IRQ_STATUS: read_mux = {30'h0, irq_status};
            OCC_ADDR_IRQ_MASK: read_mux = {30'h0, irq_mask};
            OCC_ADDR_PIN_STATE: read_mux = {29'h0, state, compare_output_pin};
            default: read_mux = 32'h0000_0000;
        endcase
    end
    assign hrdata = dp_read ? read_mux : 32'h0000_0000;

    // Assertions
    a_disabled_pin_low: assert property ( // see RULE_01
        @(posedge hclk) disable iff (!hresetn)
        !$past(enable) |-> !compare_output_pin)
        else $error("pin not low while disabled");
    a_idle_freezes_pin: assert property ( // see RULE_02
        @(posedge hclk) disable iff (!hresetn)
        (enable && stop_in_idle && chip_idle) |=> $stable(compare_output_pin))
        else $error("pin moved while halted in idle");
    a_narrow_compare: assert property ( // see RULE_03 see RULE_16
        @(posedge hclk) disable iff (!hresetn)
        (running && !wide_compare_select && compare_mode_select == OCC_MODE_RISE
         && !mode_entry && timebase[15:0] == primary_compare_value[15:0])
        |=> compare_output_pin)
        else $error("narrow compare missed");
    a_wide_compare: assert property ( // see RULE_03 see RULE_16
        @(posedge hclk) disable iff (!hresetn)
        (running && wide_compare_select && compare_mode_select == OCC_MODE_RISE
         && !mode_entry && timebase == primary_compare_value)
        |=> compare_output_pin)
        else $error("wide compare missed");
    a_fault_sets_flag: assert property ( // see RULE_04
        @(posedge hclk) disable iff (!hresetn)
        fault_event |=> pwm_fault_flag)
        else $error("fault flag not set");
    a_flag_clears: assert property ( // see RULE_04 see RULE_05
        @(posedge hclk) disable iff (!hresetn)
        !fault_mode |=> !pwm_fault_flag)
        else $error("fault flag kept outside mode 111");
    a_fault_reads_zero: assert property ( // see RULE_05
        @(posedge hclk) disable iff (!hresetn)
        !fault_mode |-> !control_view[OCC_BIT_FAULT])
        else $error("fault flag visible outside mode 111");
    // A rewrite to mode 010 just after the fault may raise the pin legally
    sequence s_fault_hold;
        !compare_output_pin
        ##1 (!compare_output_pin || $past(compare_mode_select) == OCC_MODE_FALL);
    endsequence
    a_fault_forces_low: assert property ( // see RULE_07
        @(posedge hclk) disable iff (!hresetn)
        (fault_event && enable) |=> s_fault_hold)
        else $error("pwm not held low on fault");
    a_pwm_period: assert property ( // see RULE_07
        @(posedge hclk) disable iff (!hresetn)
        (running && !mode_entry && is_pwm && !fault_event && !pwm_fault_flag
         && match_secondary)
        |=> compare_output_pin)
        else $error("pwm period did not start high");
    a_toggle_inverts: assert property ( // see RULE_10
        @(posedge hclk) disable iff (!hresetn)
        (running && !mode_entry && compare_mode_select == OCC_MODE_TOGGLE && match_primary)
        |=> compare_output_pin != $past(compare_output_pin))
        else $error("toggle did not invert");
    a_fall_entry_high: assert property ( // see RULE_11
        @(posedge hclk) disable iff (!hresetn)
        (mode_entry && compare_mode_select == OCC_MODE_FALL) |=> compare_output_pin)
        else $error("mode 010 did not start high");
    a_entry_low: assert property ( // see RULE_08 see RULE_09 see RULE_12
        @(posedge hclk) disable iff (!hresetn)
        (mode_entry && compare_mode_select != OCC_MODE_FALL) |=> !compare_output_pin)
        else $error("mode entry did not start low");
    a_rise_sets_high: assert property ( // see RULE_12
        @(posedge hclk) disable iff (!hresetn)
        (running && !mode_entry && compare_mode_select == OCC_MODE_RISE && match_primary)
        |=> compare_output_pin)
        else $error("mode 001 did not set the pin");
    sequence s_single_pulse;
        compare_output_pin ##1 (!compare_output_pin && state == OCC_ST_DONE);
    endsequence
    a_single_ends: assert property ( // see RULE_09
        @(posedge hclk) disable iff (!hresetn)
        (running && !mode_entry && compare_mode_select == OCC_MODE_SINGLE
         && state == OCC_ST_WAIT_FALL && match_secondary) |-> s_single_pulse)
        else $error("single pulse repeated");
    a_single_stays: assert property ( // see RULE_09
        @(posedge hclk) disable iff (!hresetn)
        (running && !mode_entry && compare_mode_select == OCC_MODE_SINGLE
         && state == OCC_ST_DONE) |=> (state == OCC_ST_DONE && !compare_output_pin))
        else $error("single pulse mode left its end state");
    a_train_repeats: assert property ( // see RULE_08
        @(posedge hclk) disable iff (!hresetn)
        (running && !mode_entry && compare_mode_select == OCC_MODE_TRAIN
         && state == OCC_ST_WAIT_FALL && match_secondary)
        |=> (!compare_output_pin && state == OCC_ST_WAIT_RISE))
        else $error("pulse train stopped");
    a_off_holds: assert property ( // see RULE_13
        @(posedge hclk) disable iff (!hresetn)
        (running && !mode_entry && compare_mode_select == OCC_MODE_OFF)
        |=> $stable(compare_output_pin))
        else $error("mode 000 moved the pin");
    a_reserved_zero: assert property ( // see RULE_15
        @(posedge hclk) disable iff (!hresetn)
        (control_view[31:16] == 16'h0 && control_view[14] == 1'b0
         && control_view[12:6] == 7'h0))
        else $error("reserved control bit set");
endmodule
`default_nettype wire

// file: pkg/occ_pkg.sv
/*
 * Package for the output compare channel: register offsets, control field
 * positions, reset values, mode encodings and the timer bundle struct.
 * Assumes a single AHB-Lite slave on a 32-bit bus.
 */
package occ_pkg;
    // Register byte addresses
    localparam logic [7:0] OCC_ADDR_CONTROL = 8'h00;
    localparam logic [7:0] OCC_ADDR_PRIMARY = 8'h04;
    localparam logic [7:0] OCC_ADDR_SECONDARY = 8'h08;
    localparam logic [7:0] OCC_ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OCC_ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] OCC_ADDR_PIN_STATE = 8'h14;

    // Control field positions
    localparam int OCC_BIT_ENABLE = 15;
    localparam int OCC_BIT_STOP_IDLE = 13;
    localparam int OCC_BIT_WIDE = 5;
    localparam int OCC_BIT_FAULT = 4;
    localparam int OCC_BIT_TSEL = 3;
    localparam int OCC_MODE_LSB = 0;

    // Writable control bits; all others except fault bit 4 read as zero
    localparam logic [31:0] OCC_CONTROL_WMASK = 32'h0000_a02f;
    localparam logic [31:0] OCC_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] OCC_VALUE_RESET = 32'h0000_0000;

    // Interrupt status bits
    localparam int OCC_IRQ_MATCH = 0;
    localparam int OCC_IRQ_FAULT = 1;
    localparam int OCC_IRQ_WIDTH = 2;

    localparam logic [1:0] OCC_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        OCC_MODE_OFF = 3'h0,
        OCC_MODE_RISE = 3'h1,
        OCC_MODE_FALL = 3'h2,
        OCC_MODE_TOGGLE = 3'h3,
        OCC_MODE_SINGLE = 3'h4,
        OCC_MODE_TRAIN = 3'h5,
        OCC_MODE_PWM = 3'h6,
        OCC_MODE_PWM_FAULT = 3'h7
    } occ_mode_t;

    // Gray-coded pulse sequencer states
    typedef enum logic [1:0] {
        OCC_ST_IDLE = 2'b00,
        OCC_ST_WAIT_RISE = 2'b01,
        OCC_ST_WAIT_FALL = 2'b11,
        OCC_ST_DONE = 2'b10
    } occ_state_t;

    typedef struct packed {
        logic [31:0] second_timer;
        logic [31:0] third_timer;
    } occ_timers_t;
endpackage

// file: tb/occ_load.sv
/*
 * Model of the load on the compare output pin and of the fault source.
 * Assumes the fault line has a pull-up, so a released line reads high.
 */
`timescale 1ns/100ps
`default_nettype none
module occ_load (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench control
    input wire logic fault_req,
    output logic [7:0] rise_cnt,
    // Pins
    input wire logic compare_output_pin,
    output logic fault_pin_n
);
    logic last;

    // Pulled low only while a fault is requested
    assign fault_pin_n = !fault_req;

    // Counts rising edges so pulse counts can be judged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last <= 1'b0;
            rise_cnt <= 8'h00;
        end else begin
            last <= compare_output_pin;
            if (compare_output_pin && !last) begin
                rise_cnt <= rise_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
/*
 * Testbench for the output compare channel: AHB-Lite register tasks and
 * tests of modes, timebase, idle, interrupt and fault.
 * Assumes occ_pkg, occ_top and occ_load are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import occ_pkg::*;
    localparam logic [31:0] P = 32'h0001_0010;
    localparam logic [31:0] S = 32'h0000_0020;
    localparam logic [31:0] Z = 32'h0000_7777;
    // Pin after entry and after each of three events, per mode
    localparam logic [3:0] EXP [8] = '{4'h0, 4'h7, 4'h8, 4'h5, 4'h4, 4'h5, 4'h2, 4'h2};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic chip_idle = 1'b0;
    logic fault_req = 1'b0;
    occ_timers_t timers = {Z, Z};
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pin;
    logic irq;
    logic fault_pin_n;
    logic [7:0] rise_cnt;
    logic [31:0] q;
    logic prev;
    int error_cnt = 0;
    int num_checks = 0;
    int rises = 0;

    always #4 hclk = ~hclk;

    occ_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timers(timers), .chip_idle(chip_idle), .fault_pin_n(fault_pin_n),
        .compare_output_pin(pin), .irq(irq));
    occ_load i_load (.hclk(hclk), .hresetn(hresetn), .fault_req(fault_req),
        .rise_cnt(rise_cnt), .compare_output_pin(pin), .fault_pin_n(fault_pin_n));

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic flag(input string what, input logic got, input logic exp);
        chk(what, {31'h0, got}, {31'h0, exp});
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= OCC_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        flag("hresp", hresp, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(what, q, exp);
    endtask

    // Timer values stand for one cycle only, then return to a non-matching value
    task automatic fire(input logic [31:0] t2, input logic [31:0] t3);
        @(posedge hclk);
        timers <= {t2, t3};
        @(posedge hclk);
        timers <= {Z, Z};
        repeat (2) @(posedge hclk);
    endtask

    task automatic restart(input logic [31:0] ctl);
        bus(1'b1, OCC_ADDR_CONTROL, 32'h0);
        @(posedge hclk);
        bus(1'b1, OCC_ADDR_CONTROL, ctl);
        repeat (2) @(posedge hclk);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a <= 24; a += 4) begin
            rd(a[7:0], 32'h0, "reset value");
        end
        bus(1'b1, 8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0, "unmapped");
        bus(1'b1, OCC_ADDR_CONTROL, 32'hffff_ffff);
        rd(OCC_ADDR_CONTROL, 32'h0000_a02f, "control");
        bus(1'b1, OCC_ADDR_PRIMARY, P);
        bus(1'b1, OCC_ADDR_SECONDARY, S);
        rd(OCC_ADDR_PRIMARY, P, "primary");
        rd(OCC_ADDR_SECONDARY, S, "secondary");
        done("registers");
        for (int m = 0; m < 8; m++) begin
            restart({16'h0, 1'b1, 12'h0, m[2:0]});
            prev = 1'b0;
            for (int k = 3; k >= 0; k--) begin
                if (k < 3) begin
                    if (m >= 4 && k == 1) begin
                        fire(S, S);
                    end else begin
                        fire(P, P);
                    end
                end
                flag("pin", pin, EXP[m][k]);
                rises += int'(EXP[m][k] && !prev);
                prev = EXP[m][k];
            end
            if (m == 4) begin
                rd(OCC_ADDR_PIN_STATE, {29'h0, OCC_ST_DONE, 1'b0}, "pin state");
            end
        end
        chk("pin rises", {24'h0, rise_cnt}, 32'(rises));
        done("modes");
        restart(32'h0000_8009);
        fire(P, Z);
        flag("pin", pin, 1'b0);
        fire(Z, 32'h0000_0010);
        flag("pin", pin, 1'b1);
        restart(32'h0000_8021);
        fire(32'h0000_0010, Z);
        flag("pin", pin, 1'b0);
        fire(P, Z);
        flag("pin", pin, 1'b1);
        done("timebase");
        restart(32'h0000_0001);
        fire(P, P);
        flag("pin", pin, 1'b0);
        restart(32'h0000_a001);
        chip_idle <= 1'b1;
        fire(P, P);
        flag("pin", pin, 1'b0);
        chip_idle <= 1'b0;
        fire(P, P);
        flag("pin", pin, 1'b1);
        chip_idle <= 1'b1;
        repeat (2) @(posedge hclk);
        chip_idle <= 1'b0;
        repeat (2) @(posedge hclk);
        flag("pin", pin, 1'b1);
        restart(32'h0000_8001);
        chip_idle <= 1'b1;
        fire(P, P);
        flag("pin", pin, 1'b1);
        chip_idle <= 1'b0;
        done("idle");
        restart(32'h0000_8001);
        bus(1'b0, OCC_ADDR_IRQ_STATUS, 32'h0);
        fire(P, P);
        flag("irq", irq, 1'b0);
        bus(1'b1, OCC_ADDR_IRQ_MASK, 32'h1);
        @(posedge hclk);
        flag("irq", irq, 1'b1);
        rd(OCC_ADDR_IRQ_STATUS, 32'h1, "status");
        @(posedge hclk);
        flag("irq", irq, 1'b0);
        done("interrupt");
        restart(32'h0000_8007);
        bus(1'b1, OCC_ADDR_IRQ_MASK, 32'h2);
        fire(S, S);
        flag("pin", pin, 1'b1);
        fault_req <= 1'b1;
        repeat (6) @(posedge hclk);
        flag("pin", pin, 1'b0);
        flag("irq", irq, 1'b1);
        rd(OCC_ADDR_CONTROL, 32'h0000_8017, "control");
        rd(OCC_ADDR_IRQ_STATUS, 32'h2, "status");
        restart(32'h0000_8006);
        rd(OCC_ADDR_CONTROL, 32'h0000_8006, "control");
        fire(S, S);
        flag("pin", pin, 1'b1);
        fault_req <= 1'b0;
        done("fault");
        summarize();
    end

    // The whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
